//--- core/ccl_comparator.v
`timescale 1ns/1ps
`default_nettype none
`include "ccl_regs.vh"

// Functional notes
// - comparator runs only while enable bit 7 of control a is one.
// - result is one when plus node exceeds minus node, inverted by invert bit.
// - pin drive enable routes result to pin; pin driven only if direction bit clear.
// - invert bit 4 of control a flips the result when set.
// - speed bit 2 picks fast mode when one, slow when zero; resets to one.
// - bit 1 of control a drives the analog hysteresis enable.
// - sync bit set latches result on Timer1 clock falling edge; else passes through.
// - rise enable bit 7 of control b lets rising result edges set the flag.
// - fall enable bit 6 of control b lets falling result edges set the flag.
// - plus select codes 00,01,10 route dedicated pin, DAC, fixed reference.
// - plus code 11 routes shared plus pin on channel one, ground on two.
// - minus select codes 00 to 11 route shared minus pins 0 to 3.
// - mirror register shows channel two in bit 1, channel one in bit 0.
// - unimplemented control bits ignore writes and read zero.
// - all control bits reset alike for every reset; zero except speed bit.
// - event flag stays until software clears it; a new edge wins over clear.
// - edges seen on conditioned result, so invert or enable toggles can flag.
// - internal result registered every cycle; pin path follows sync selection.
module ccl_comparator
(
  input  wire        CLK_SYS,
  input  wire        RESETN,
  input  wire        WB_CYC_I,
  input  wire        WB_STB_I,
  input  wire        WB_WE_I,
  input  wire [7:0]  WB_ADR_I,
  input  wire [3:0]  WB_SEL_I,
  input  wire [31:0] WB_DAT_I,
  output reg  [31:0] WB_DAT_O,
  output reg         WB_ACK_O,
  input  wire [1:0]  CMP_RAW,
  input  wire        T1_CLK,
  input  wire [1:0]  PIN_DIRECTION_BIT,
  output wire [1:0]  CMP_ENABLE,
  output wire [1:0]  CMP_SPEED_SELECT,
  output wire [1:0]  CMP_HYSTERESIS_ENABLE,
  output wire [9:0]  PLUS_ROUTE,
  output wire [7:0]  MINUS_ROUTE,
  output wire [1:0]  CMP_PIN_O,
  output wire [1:0]  CMP_PIN_OE,
  output wire [1:0]  CMP_T1_OUT,
  output wire [1:0]  CMP_EVENT_FLAG
);

  wire        req_w;
  wire        wr_w;
  wire [15:0] ctrl_a_w;
  wire [15:0] ctrl_b_w;
  wire [1:0]  result_w;
  reg         t1_s1_q;
  reg         t1_s2_q;
  reg         t1_p_q;
  wire        t1_fall_w;

  // new request seen while no ack is out; writes need the low byte lane
  assign req_w = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign wr_w  = req_w & WB_WE_I & WB_SEL_I[0];

  // timer1 clock synchroniser and falling edge detect
  always @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      t1_s1_q <= 1'b0;
      t1_s2_q <= 1'b0;
      t1_p_q  <= 1'b0;
    end
    else
    begin
      t1_s1_q <= T1_CLK;
      t1_s2_q <= t1_s1_q;
      t1_p_q  <= t1_s2_q;
    end
  end

  assign t1_fall_w = t1_p_q & ~t1_s2_q;

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1)
    begin : g_ch
      reg  [7:0] ctrl_a_q;
      reg  [7:0] ctrl_b_q;
      reg        raw_s1_q;
      reg        raw_s2_q;
      reg        result_q;
      reg        prev_q;
      reg        pin_q;
      reg        oe_q;
      reg        flag_q;
      reg  [4:0] plus_q;
      reg  [3:0] minus_q;
      wire [7:0] ofs_a;
      wire [7:0] ofs_b;
      wire       cond_w;
      wire       rise_w;
      wire       fall_w;
      wire       clr_w;

      // channel offsets, cut to the address width on purpose
      localparam integer OFS_A_I = `CCL_OFS_CTRL_A1 + i * `CCL_CH_STRIDE;
      localparam integer OFS_B_I = `CCL_OFS_CTRL_B1 + i * `CCL_CH_STRIDE;

      assign ofs_a = OFS_A_I[7:0];
      assign ofs_b = OFS_B_I[7:0];

      // control registers, unimplemented bits masked off
      always @(posedge CLK_SYS)
      begin
        if (!RESETN)
        begin
          ctrl_a_q <= `CCL_A_RESET;
          ctrl_b_q <= `CCL_B_RESET;
        end
        else
        begin
          if (wr_w && WB_ADR_I == ofs_a)
            ctrl_a_q <= WB_DAT_I[7:0] & `CCL_A_WMASK;
          if (wr_w && WB_ADR_I == ofs_b)
            ctrl_b_q <= WB_DAT_I[7:0] & `CCL_B_WMASK;
        end
      end

      // off channel reads as zero before inversion
      assign cond_w = (raw_s2_q & ctrl_a_q[`CCL_A_ENABLE]) ^ ctrl_a_q[`CCL_A_INVERT];
      assign rise_w = result_q & ~prev_q & ctrl_b_q[`CCL_B_RISE_EN];
      assign fall_w = ~result_q & prev_q & ctrl_b_q[`CCL_B_FALL_EN];
      assign clr_w  = wr_w && WB_ADR_I == `CCL_OFS_FLAGS && WB_DAT_I[i];

      // synchroniser, result, edges, pin path and flag
      always @(posedge CLK_SYS)
      begin
        if (!RESETN)
        begin
          raw_s1_q <= 1'b0;
          raw_s2_q <= 1'b0;
          result_q <= 1'b0;
          prev_q   <= 1'b0;
          pin_q    <= 1'b0;
          oe_q     <= 1'b0;
          flag_q   <= 1'b0;
        end
        else
        begin
          raw_s1_q <= CMP_RAW[i];
          raw_s2_q <= raw_s1_q;
          result_q <= cond_w;
          prev_q   <= result_q;
          if (!ctrl_a_q[`CCL_A_SYNC] || t1_fall_w)
            pin_q <= cond_w;
          oe_q <= ctrl_a_q[`CCL_A_PIN_DRIVE] & ~PIN_DIRECTION_BIT[i];
          if (rise_w || fall_w)
            flag_q <= 1'b1;
          else if (clr_w)
            flag_q <= 1'b0;
        end
      end

      // analog input routing, all inputs off while disabled
      always @(posedge CLK_SYS)
      begin
        if (!RESETN)
        begin
          plus_q  <= 5'h00;
          minus_q <= 4'h0;
        end
        else
        begin
          plus_q  <= 5'h00;
          minus_q <= 4'h0;
          if (ctrl_a_q[`CCL_A_ENABLE])
          begin
            minus_q[ctrl_b_q[`CCL_B_MINUS_HI:`CCL_B_MINUS_LO]] <= 1'b1;
            case (ctrl_b_q[`CCL_B_PLUS_HI:`CCL_B_PLUS_LO])
              `CCL_PLUS_PIN:   plus_q[`CCL_PR_PIN]   <= 1'b1;
              `CCL_PLUS_DAC:   plus_q[`CCL_PR_DAC]   <= 1'b1;
              `CCL_PLUS_FIXED: plus_q[`CCL_PR_FIXED] <= 1'b1;
              default:         plus_q[(i == 0) ? `CCL_PR_SHARED : `CCL_PR_GROUND] <= 1'b1;
            endcase
          end
        end
      end

      assign ctrl_a_w[8*i +: 8]     = {ctrl_a_q[7], result_q, ctrl_a_q[5:0]};
      assign ctrl_b_w[8*i +: 8]     = ctrl_b_q;
      assign result_w[i]            = result_q;
      assign CMP_ENABLE[i]          = ctrl_a_q[`CCL_A_ENABLE];
      assign CMP_SPEED_SELECT[i]    = ctrl_a_q[`CCL_A_SPEED];
      assign CMP_HYSTERESIS_ENABLE[i] = ctrl_a_q[`CCL_A_HYST];
      assign PLUS_ROUTE[5*i +: 5]   = plus_q;
      assign MINUS_ROUTE[4*i +: 4]  = minus_q;
      assign CMP_PIN_O[i]           = pin_q;
      assign CMP_PIN_OE[i]          = oe_q;
      assign CMP_T1_OUT[i]          = pin_q;
      assign CMP_EVENT_FLAG[i]      = flag_q;
    end
  endgenerate

  // wishbone answer: ack one cycle after request, read data with it
  always @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end
    else
    begin
      WB_ACK_O <= req_w;
      WB_DAT_O <= 32'h00000000;
      if (req_w && !WB_WE_I)
      begin
        case (WB_ADR_I)
          `CCL_OFS_CTRL_A1: WB_DAT_O[7:0] <= ctrl_a_w[7:0];
          `CCL_OFS_CTRL_B1: WB_DAT_O[7:0] <= ctrl_b_w[7:0];
          `CCL_OFS_CTRL_A2: WB_DAT_O[7:0] <= ctrl_a_w[15:8];
          `CCL_OFS_CTRL_B2: WB_DAT_O[7:0] <= ctrl_b_w[15:8];
          `CCL_OFS_MIRROR:  WB_DAT_O[1:0] <= result_w;
          `CCL_OFS_FLAGS:   WB_DAT_O[1:0] <= CMP_EVENT_FLAG;
          default:          WB_DAT_O    <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // ccl_comparator
`default_nettype wire

//--- core/ccl_regs.vh
`ifndef CCL_REGS_VH
`define CCL_REGS_VH

// register byte offsets, one 32-bit word each
`define CCL_OFS_CTRL_A1   8'h00
`define CCL_OFS_CTRL_B1   8'h04
`define CCL_OFS_CTRL_A2   8'h08
`define CCL_OFS_CTRL_B2   8'h0C
`define CCL_OFS_MIRROR    8'h10
`define CCL_OFS_FLAGS     8'h14
// distance between the two channels' control registers
`define CCL_CH_STRIDE     8'h08

// control register a fields
`define CCL_A_ENABLE      7
`define CCL_A_RESULT      6
`define CCL_A_PIN_DRIVE   5
`define CCL_A_INVERT      4
`define CCL_A_SPEED       2
`define CCL_A_HYST        1
`define CCL_A_SYNC        0
`define CCL_A_WMASK       8'hB7
`define CCL_A_RESET       8'h04

// control register b fields
`define CCL_B_RISE_EN     7
`define CCL_B_FALL_EN     6
`define CCL_B_PLUS_HI     5
`define CCL_B_PLUS_LO     4
`define CCL_B_MINUS_HI    1
`define CCL_B_MINUS_LO    0
`define CCL_B_WMASK       8'hF3
`define CCL_B_RESET       8'h00

// plus input select codes
`define CCL_PLUS_PIN      2'h0
`define CCL_PLUS_DAC      2'h1
`define CCL_PLUS_FIXED    2'h2
`define CCL_PLUS_ALT      2'h3

// plus route one-hot positions
`define CCL_PR_PIN        0
`define CCL_PR_DAC        1
`define CCL_PR_FIXED      2
`define CCL_PR_SHARED     3
`define CCL_PR_GROUND     4

`endif

//--- verification/ccl_analog.sv
`timescale 1ns/1ps
`default_nettype none
// analog cores and timer clock stand-in
module ccl_analog
(
  input wire logic       run,
  input wire logic [3:0] vp,
  input wire logic [3:0] vn,
  output logic [1:0]     raw,
  output logic           t1
);
  // compare per channel, two level bits each
  assign raw = {vp[3:2] > vn[3:2], vp[1:0] > vn[1:0]};
  // timer clock runs only while asked, rests low otherwise
  initial t1 = 1'b0;
  always #7.3 t1 = run & ~t1;
endmodule // ccl_analog
`default_nettype wire

//--- verification/ccl_comparator_chk.sv
`timescale 1ns/1ps
`default_nettype none
// port level checks on the comparator control block
module ccl_comparator_chk
(
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic [1:0] PIN_DIRECTION_BIT,
  input wire logic [1:0] CMP_ENABLE,
  input wire logic [9:0] PLUS_ROUTE,
  input wire logic [7:0] MINUS_ROUTE,
  input wire logic [1:0] CMP_PIN_O,
  input wire logic [1:0] CMP_PIN_OE,
  input wire logic [1:0] CMP_T1_OUT,
  input wire logic [1:0] CMP_EVENT_FLAG
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  wire logic req = WB_CYC_I & WB_STB_I;
  // bus answer timing
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
  a_ack_answer: assert property (req && !WB_ACK_O |=> WB_ACK_O) else $error("ack missing");
  // register and pin relations
  a_mirror_zero: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I == 8'h10 |-> WB_DAT_O[31:2] == 30'h0)
    else $error("mirror upper bits set");
  a_pin_dir: assert property ((CMP_PIN_OE & $past(PIN_DIRECTION_BIT)) == 2'h0) else $error("input pin driven");
  a_t1_pin: assert property (CMP_T1_OUT == CMP_PIN_O) else $error("timer copy differs");
  a_off_quiet: assert property (!CMP_ENABLE[0] && !$past(CMP_ENABLE[0]) |-> {PLUS_ROUTE[4:0], MINUS_ROUTE[3:0]} == 9'h0)
    else $error("routes while off");
  a_route_one: assert property (CMP_ENABLE[0] && $past(CMP_ENABLE[0]) |-> $onehot(PLUS_ROUTE[3:0])
    && !PLUS_ROUTE[4] && $onehot(MINUS_ROUTE[3:0])) else $error("bad route");
  a_flag_clear: assert property ($fell(CMP_EVENT_FLAG[0]) |-> $past(req && WB_WE_I && WB_ADR_I == 8'h14))
    else $error("flag lost");
  c_flag: cover property (CMP_EVENT_FLAG[0]);
  c_pin: cover property (CMP_PIN_OE[0] && CMP_PIN_O[0]);
  c_ground: cover property (PLUS_ROUTE[9]);
endmodule // ccl_comparator_chk
bind ccl_comparator ccl_comparator_chk u_chk (.CLK_SYS, .RESETN, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I,
  .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .PIN_DIRECTION_BIT, .CMP_ENABLE, .PLUS_ROUTE, .MINUS_ROUTE, .CMP_PIN_O,
  .CMP_PIN_OE, .CMP_T1_OUT, .CMP_EVENT_FLAG);
`default_nettype wire

//--- verification/tb_ccl_comparator.sv
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the comparator control block
module tb_ccl_comparator;
  logic clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, run = 1'b0, t1, ack;
  logic [7:0] adr = 8'h0, mr, r;
  logic [31:0] dat = 32'h0, rdat;
  logic [3:0] vp = 4'h0, vn = 4'h0;
  logic [1:0] dir = 2'h3, raw, en, hys, oe, po, spd, t1o, flg;
  logic [9:0] pr;
  logic [31:0] exp_q[$];
  int mismatches = 0, checked = 0;
  // clock
  always #2 clk = ~clk;
  ccl_analog u_ana (.run(run), .vp(vp), .vn(vn), .raw(raw), .t1(t1));
  ccl_comparator DUT (.CLK_SYS(clk), .RESETN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .CMP_RAW(raw),
    .T1_CLK(t1), .PIN_DIRECTION_BIT(dir), .CMP_ENABLE(en), .CMP_SPEED_SELECT(spd), .CMP_HYSTERESIS_ENABLE(hys),
    .PLUS_ROUTE(pr), .MINUS_ROUTE(mr), .CMP_PIN_O(po), .CMP_PIN_OE(oe), .CMP_T1_OUT(t1o), .CMP_EVENT_FLAG(flg));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, dat} <= {2'h3, w, a, d};
    do @(posedge clk); while (ack !== 1'b1);
    {cyc, stb} <= 2'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask
  task automatic w6;
    repeat (6) @(posedge clk);
  endtask
  task automatic ev(input logic [7:0] b, input logic [3:0] v, input logic [31:0] e);
    wb(1'b1, 8'h04, {24'h0, b});
    wb(1'b1, 8'h14, 32'h3);
    vp <= v;
    w6;
    rd(8'h14, e);
  endtask
  task automatic end_sim;
    if (mismatches == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // read data against the oldest note
  always @(posedge clk)
    if (ack === 1'b1 && cyc && !we)
      chk(rdat, exp_q.pop_front());
  // watchdog
  initial
  begin
    #40us;
    mismatches++;
    end_sim;
  end
  // main sequence
  initial
  begin
    void'($urandom(32'h8373));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    chk(spd, 2'h3);
    rd(8'h00, 32'h04);
    rd(8'h04, 32'h00);
    rd(8'h18, 32'h00);
    wb(1'b1, 8'h00, 32'hFF);
    wb(1'b1, 8'h08, 32'h92);
    w6;
    rd(8'h00, 32'hF7);
    rd(8'h10, 32'h03);
    chk({en, hys}, 4'hF);
    for (int j = 0; j < 2; j++)
      for (int i = 0; i < 4; i++)
      begin
        r = 8'($urandom);
        r[5:4] = i[1:0];
        r[1:0] = i[1:0];
        wb(1'b1, 8'(4 + 8 * j), {24'h0, r});
        rd(8'(4 + 8 * j), {24'h0, r & 8'hF3});
        chk(pr[5 * j +: 5], i == 3 ? 5'h8 << j : 5'h1 << i);
        chk(mr[4 * j +: 4], 4'h1 << i);
      end
    wb(1'b1, 8'h04, 32'h80);
    wb(1'b1, 8'h00, 32'h80);
    w6;
    ev(8'h80, 4'h1, 32'h1);
    ev(8'h80, 4'h0, 32'h0);
    ev(8'h40, 4'h1, 32'h0);
    ev(8'h40, 4'h0, 32'h1);
    wb(1'b1, 8'h00, 32'h00);
    ev(8'hC0, 4'h0, 32'h0);
    wb(1'b1, 8'h00, 32'h10);
    w6;
    rd(8'h14, 32'h1);
    chk(flg[0], 1'b1);
    wb(1'b1, 8'h00, 32'hA0);
    vp <= 4'h1;
    dir <= 2'h2;
    w6;
    chk({po[0], oe[0]}, 2'h3);
    dir <= 2'h3;
    w6;
    chk(oe[0], 1'b0);
    wb(1'b1, 8'h00, 32'hA1);
    vp <= 4'h0;
    w6;
    chk(po[0], 1'b1);
    run <= 1'b1;
    repeat (20) @(posedge clk);
    chk(po[0], 1'b0);
    chk(t1o[0], 1'b0);
    end_sim;
  end
endmodule // tb_ccl_comparator
`default_nettype wire
